// *** etio_pkg.sv ***
// Package for the external trigger input/output block: constants and carriers
package etio_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned DEBOUNCE_MS = 30;
    localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned PRE_TRIG_REC_S = 1;
    localparam int unsigned OUT_PULSE_MS = 10;
    localparam int unsigned OUT_PULSE_CYC = CLK_HZ / 1000 * OUT_PULSE_MS;
    localparam int unsigned MS_CYC = CLK_HZ / 1000;
    localparam int unsigned TIME_W = 16;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic PIN_IDLE = 1'b1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ETIO_EDGE_FALL = 2'h0,
        ETIO_EDGE_RISE = 2'h1,
        ETIO_EDGE_BOTH = 2'h2,
        ETIO_EDGE_OFF = 2'h3
    } etio_edge_t;

    typedef enum logic [3:0] {
        ETIO_ST_IDLE = 4'h1,
        ETIO_ST_ARMED = 4'h2,
        ETIO_ST_LOG = 4'h4,
        ETIO_ST_POST = 4'h8
    } etio_state_t;

    typedef struct packed {
        etio_edge_t edge_sel;
        logic start_on_trig;
        logic stop_on_trig;
        logic [TIME_W-1:0] pre_ms;
        logic [TIME_W-1:0] post_ms;
        logic [7:0] out_event_mask;
    } etio_cfg_t;

    typedef struct packed {
        logic armed;
        logic logging;
        logic pre_full;
        logic trig_seen;
        logic pin_level;
    } etio_stat_t;

endpackage

// *** etio_debounce.sv ***
// Debouncer: a new level is accepted only after it stands for the whole hold time
`timescale 1ns/1ps
module etio_debounce
    import etio_pkg::*;
#(
    parameter int unsigned HOLD_CYC = DEBOUNCE_CYC
) (
    ref_clk, // System clock
    rst_n, // Synchronised reset, active low
    raw_in, // Synchronised pin level
    level_out, // Debounced level
    rise_pls, // One-cycle pulse on accepted rise
    fall_pls // One-cycle pulse on accepted fall
);
    input wire logic ref_clk;
    input wire logic rst_n;
    input wire logic raw_in;
    output logic level_out;
    output logic rise_pls;
    output logic fall_pls;

    typedef struct packed {
        logic level;
        logic [31:0] cnt;
        logic rise;
        logic fall;
    } etio_db_t;

    etio_db_t st_reg;
    etio_db_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.rise = 1'b0;
        st_next.fall = 1'b0;
        if (raw_in == st_reg.level) begin
            st_next.cnt = '0; // see RULE3
        end else if (st_reg.cnt >= HOLD_CYC - 1) begin
            st_next.cnt = '0;
            st_next.level = raw_in;
            st_next.rise = raw_in;
            st_next.fall = ~raw_in;
        end else begin
            st_next.cnt = st_reg.cnt + 32'h1; // see RULE3
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{level: PIN_IDLE, cnt: '0, rise: 1'b0, fall: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.level;
    assign rise_pls = st_reg.rise;
    assign fall_pls = st_reg.fall;

    // A new level that has not yet stood the full hold time must leave the output alone
    a_short_glitch: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE3
        ((raw_in != level_out) && (st_reg.cnt < HOLD_CYC - 1)) |=> $stable(level_out))
        else $error("debounced level changed on a short glitch");

endmodule // etio_debounce

// *** etio_top.sv ***
// External trigger input/output: sync, debounce, edge select, log control, pulse out
`timescale 1ns/1ps
// What this block does
// RULE1 - Falling edge config: trigger on pull low
// RULE2 - Rising edge config: trigger on release high
// RULE3 - Ignore level changes shorter than 30 ms
// RULE4 - Open input reads high via pull-up
// RULE5 - Single output pulse on selected internal event
// RULE6 - Qualified falling edge can start logging
// RULE7 - Post-trigger time zero means log forever
// RULE8 - Pre-trigger time keeps earlier data
// RULE9 - Two flip-flop synchroniser before debounce
module etio_top
    import etio_pkg::*;
#(
    parameter int unsigned HOLD_CYC = DEBOUNCE_CYC,
    parameter int unsigned PULSE_CYC = OUT_PULSE_CYC,
    parameter int unsigned TICK_CYC = MS_CYC
) (
    ref_clk, // 40 MHz clock
    rst_n, // Asynchronous reset, active low
    trig_in, // Trigger input pin, pulled up
    cfg, // Configuration bits
    arm, // Pulse: arm the trigger logic
    disarm, // Pulse: return to idle
    event_in, // Internal events, bit 0 is storage full
    trig_out, // Trigger output pulse, active high
    trig_pls, // One-cycle pulse on qualified trigger
    stat // Status bits
);
    input wire logic ref_clk;
    input wire logic rst_n;
    input wire logic trig_in;
    input etio_pkg::etio_cfg_t cfg;
    input wire logic arm;
    input wire logic disarm;
    input wire logic [7:0] event_in;
    output logic trig_out;
    output logic trig_pls;
    output etio_pkg::etio_stat_t stat;

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_sync_reg;
    logic rst_n_s;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_s = rst_sync_reg[1];

    // ************************************************************
    // Input path
    // ************************************************************
    logic sync1_reg;
    logic sync2_reg;
    // Both stages reset high: an open pin is idle high, so no false edge after reset
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            sync1_reg <= PIN_IDLE; // see RULE4
            sync2_reg <= PIN_IDLE;
        end else begin
            sync1_reg <= trig_in; // see RULE9
            sync2_reg <= sync1_reg; // see RULE9
        end
    end

    logic db_level;
    logic db_rise;
    logic db_fall;
    etio_debounce #(.HOLD_CYC(HOLD_CYC)) u_db (
        .ref_clk(ref_clk),
        .rst_n(rst_n_s),
        .raw_in(sync2_reg),
        .level_out(db_level),
        .rise_pls(db_rise),
        .fall_pls(db_fall)
    );

    function automatic logic edge_hit(etio_edge_t sel, logic rise, logic fall);
        case (sel)
            ETIO_EDGE_FALL: edge_hit = fall; // see RULE1
            ETIO_EDGE_RISE: edge_hit = rise; // see RULE2
            ETIO_EDGE_BOTH: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    logic hit;
    assign hit = edge_hit(cfg.edge_sel, db_rise, db_fall);

    // ************************************************************
    // Control state
    // ************************************************************
    typedef struct packed {
        etio_state_t fsm;
        logic [$clog2(TICK_CYC+1)-1:0] tick_cnt;
        logic [TIME_W-1:0] pre_cnt;
        logic [TIME_W-1:0] post_cnt;
        logic pre_full;
        logic trig_seen;
        logic trig;
        logic [31:0] out_cnt;
        logic out;
        logic [7:0] ev_prev;
    } etio_st_t;

    etio_st_t st_reg;
    etio_st_t st_next;
    logic ms_tick;
    logic ev_fire;

    assign ms_tick = (st_reg.tick_cnt == ($clog2(TICK_CYC+1))'(TICK_CYC - 1));
    assign ev_fire = |(event_in & ~st_reg.ev_prev & cfg.out_event_mask);

    always_comb begin
        st_next = st_reg;
        st_next.trig = 1'b0;
        st_next.ev_prev = event_in;
        st_next.tick_cnt = ms_tick ? '0 : st_reg.tick_cnt + 1'b1;
        case (st_reg.fsm)
            ETIO_ST_IDLE: begin
                if (arm) begin
                    st_next.fsm = ETIO_ST_ARMED;
                    st_next.pre_cnt = '0;
                    st_next.pre_full = (cfg.pre_ms == '0);
                    st_next.trig_seen = 1'b0;
                end
            end
            ETIO_ST_ARMED: begin
                // Pre-trigger window fills while armed; the recorder keeps that span
                if (ms_tick && !st_reg.pre_full) begin
                    st_next.pre_cnt = st_reg.pre_cnt + 1'b1; // see RULE8
                    st_next.pre_full = (st_reg.pre_cnt + 1'b1 >= cfg.pre_ms);
                end
                if (disarm) begin
                    st_next.fsm = ETIO_ST_IDLE;
                end else if (hit && cfg.start_on_trig) begin
                    st_next.fsm = ETIO_ST_LOG; // see RULE6
                    st_next.trig = 1'b1;
                    st_next.trig_seen = 1'b1;
                end
            end
            ETIO_ST_LOG: begin
                if (disarm) begin
                    st_next.fsm = ETIO_ST_IDLE;
                end else if (hit && cfg.stop_on_trig) begin
                    st_next.trig = 1'b1;
                    st_next.post_cnt = '0;
                    // Zero post time: a stop trigger stays in logging; only disarm ends it
                    if (cfg.post_ms != '0) begin
                        st_next.fsm = ETIO_ST_POST; // see RULE7
                    end
                end
            end
            ETIO_ST_POST: begin
                if (disarm) begin
                    st_next.fsm = ETIO_ST_IDLE;
                end else if (ms_tick) begin
                    st_next.post_cnt = st_reg.post_cnt + 1'b1;
                    if (st_reg.post_cnt + 1'b1 >= cfg.post_ms) begin
                        st_next.fsm = ETIO_ST_IDLE;
                    end
                end
            end
            default: st_next.fsm = ETIO_ST_IDLE;
        endcase
        // Single output pulse; a new event during the pulse is merged, not stretched
        if (st_reg.out) begin
            if (st_reg.out_cnt >= PULSE_CYC - 1) begin
                st_next.out = 1'b0;
            end else begin
                st_next.out_cnt = st_reg.out_cnt + 32'h1;
            end
        end else if (ev_fire) begin
            st_next.out = 1'b1; // see RULE5
            st_next.out_cnt = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            st_reg <= '{fsm: ETIO_ST_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign trig_out = st_reg.out;
    assign trig_pls = st_reg.trig;
    // One driver for the whole status word, so no field has a second driver
    assign stat = '{
        armed: (st_reg.fsm == ETIO_ST_ARMED),
        logging: (st_reg.fsm == ETIO_ST_LOG) || (st_reg.fsm == ETIO_ST_POST),
        pre_full: st_reg.pre_full,
        trig_seen: st_reg.trig_seen,
        pin_level: db_level
    };

    // ************************************************************
    // Checks
    // ************************************************************
    a_fall_trig: assert property (@(posedge ref_clk) disable iff (!rst_n_s) // see RULE1
        (stat.armed && db_fall && cfg.edge_sel == ETIO_EDGE_FALL && cfg.start_on_trig && !disarm)
        |=> trig_pls && stat.logging)
        else $error("falling edge did not start logging");
    a_rise_trig: assert property (@(posedge ref_clk) disable iff (!rst_n_s) // see RULE2
        (stat.armed && db_rise && cfg.edge_sel == ETIO_EDGE_RISE && cfg.start_on_trig && !disarm)
        |=> trig_pls)
        else $error("rising edge did not trigger");
    a_no_wrong_edge: assert property (@(posedge ref_clk) disable iff (!rst_n_s) // see RULE1
        (db_rise && cfg.edge_sel == ETIO_EDGE_FALL) |=> !trig_pls)
        else $error("trigger on wrong edge");
    a_pin_idle_high: assert property (@(posedge ref_clk) disable iff (!rst_n_s) // see RULE4
        $rose(rst_n_s) |-> db_level)
        else $error("input not idle high after reset");
    a_sync_delay: assert property (@(posedge ref_clk) disable iff (!rst_n_s) // see RULE9
        $fell(sync2_reg) |-> $past(trig_in, 2) == 1'b0)
        else $error("synchroniser depth wrong");
    a_out_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n_s) // see RULE5
        (!trig_out && ev_fire) |=> trig_out)
        else $error("event gave no output pulse");
    a_out_ends: assert property (@(posedge ref_clk) disable iff (!rst_n_s) // see RULE5
        (trig_out && st_reg.out_cnt >= PULSE_CYC - 1) |=> !trig_out)
        else $error("output pulse not single");
    a_post_zero: assert property (@(posedge ref_clk) disable iff (!rst_n_s) // see RULE7
        (st_reg.fsm == ETIO_ST_LOG && cfg.post_ms == '0 && !disarm) |=> st_reg.fsm == ETIO_ST_LOG)
        else $error("zero post time ended logging");
    a_pre_count: assert property (@(posedge ref_clk) disable iff (!rst_n_s) // see RULE8
        (stat.armed && !stat.pre_full && ms_tick && !disarm && !hit)
        |=> st_reg.pre_cnt == $past(st_reg.pre_cnt) + 1'b1)
        else $error("pre-trigger time not counted");

    c_start: cover property (@(posedge ref_clk) disable iff (!rst_n_s) stat.armed ##1 stat.logging);
    c_post_end: cover property (@(posedge ref_clk) disable iff (!rst_n_s)
        st_reg.fsm == ETIO_ST_POST ##1 st_reg.fsm == ETIO_ST_IDLE);
    c_out: cover property (@(posedge ref_clk) disable iff (!rst_n_s) $rose(trig_out));

endmodule // etio_top

// *** etio_switch_model.sv ***
// Far-side model of the trigger pin: a switch to ground against the internal pull-up
`timescale 1ns/1ps
module etio_switch_model (
    sw_closed, // Switch contact closed to ground
    pin // Level seen on the trigger pin
);
    input wire logic sw_closed;
    output logic pin;
    // An open switch leaves the pin to the pull-up, never to the last driven value
    assign pin = sw_closed ? 1'b0 : 1'b1;
endmodule // etio_switch_model

// *** tb_top.sv ***
// Self-checking testbench for the external trigger input/output block
`timescale 1ns/1ps
module tb_top;
    import etio_pkg::*;
    localparam int HOLD = 8;
    localparam int PULSE = 4;
    localparam int TICK = 4;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sw_closed = 1'b0;
    logic trig_in;
    etio_cfg_t cfg = '0;
    logic arm = 1'b0;
    logic disarm = 1'b0;
    logic [7:0] event_in = 8'h00;
    logic trig_out;
    logic trig_pls;
    etio_stat_t stat;
    int mismatches = 0;
    int checked = 0;
    int seed = 71;
    int n_trig = 0;
    int n_out = 0;
    int run_len = 0;
    logic model_lvl = 1'b1;
    logic edge_q[$];
    logic [7:0] rnd;

    always #12.5 ref_clk = ~ref_clk;

    etio_switch_model etio_switch_model_inst (.sw_closed(sw_closed), .pin(trig_in));
    etio_top #(.HOLD_CYC(HOLD), .PULSE_CYC(PULSE), .TICK_CYC(TICK)) etio_top_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .trig_in(trig_in), .cfg(cfg), .arm(arm),
        .disarm(disarm), .event_in(event_in), .trig_out(trig_out), .trig_pls(trig_pls), .stat(stat));

    // ************************************************************
    // Reference model: accepted pin edges, output activity
    // ************************************************************
    always @(posedge ref_clk) begin
        if (trig_pls === 1'b1) n_trig++;
        if (trig_out === 1'b1) n_out++;
        // Level must stand HOLD cycles before it counts as an edge
        if (trig_in !== model_lvl) run_len++;
        else run_len = 0;
        if (run_len == HOLD) begin
            model_lvl = trig_in;
            edge_q.push_back(trig_in);
            run_len = 0;
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Expected pulses are the queued edges that the current state lets qualify
    task automatic expect_trigs(input logic fall_ok, input logic rise_ok);
        int exp;
        exp = 0;
        while (edge_q.size() > 0) begin
            if (edge_q.pop_front()) exp += rise_ok;
            else exp += fall_ok;
        end
        check("trig_pls count", n_trig, exp);
        n_trig = 0;
    endtask

    task automatic pin_pulse(input int len);
        sw_closed = 1'b1;
        step(len);
        sw_closed = 1'b0;
        step(HOLD + 8);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        wrap_up;
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        step(20);
        rst_n = 1'b1;
        step(4);
        check("pin_level open", stat.pin_level, 1);
        check("logging after reset", stat.logging, 0);
        cfg.edge_sel = ETIO_EDGE_FALL;
        cfg.start_on_trig = 1'b1;
        cfg.pre_ms = 16'h0001;
        cfg.out_event_mask = 8'h01;
        pulse(arm);
        step(20);
        check("armed", stat.armed, 1);
        check("trig_seen armed", stat.trig_seen, 0);
        check("pre_full", stat.pre_full, 1);
        pin_pulse(HOLD - 3);
        expect_trigs(1'b1, 1'b0);
        check("logging after glitch", stat.logging, 0);
        sw_closed = 1'b1;
        step(HOLD + 8);
        expect_trigs(1'b1, 1'b0);
        check("logging on fall", stat.logging, 1);
        check("trig_seen on fall", stat.trig_seen, 1);
        check("pin_level closed", stat.pin_level, model_lvl);
        sw_closed = 1'b0;
        step(HOLD + 8);
        expect_trigs(1'b0, 1'b0);
        cfg.stop_on_trig = 1'b1;
        pin_pulse(HOLD + 8);
        expect_trigs(1'b1, 1'b0);
        step(40);
        check("logging post zero", stat.logging, 1);
        pulse(disarm);
        check("logging after disarm", stat.logging, 0);
        cfg.edge_sel = ETIO_EDGE_RISE;
        cfg.post_ms = 16'h0002;
        pulse(arm);
        sw_closed = 1'b1;
        step(HOLD + 8);
        expect_trigs(1'b0, 1'b1);
        sw_closed = 1'b0;
        step(HOLD + 8);
        expect_trigs(1'b0, 1'b1);
        check("logging on rise", stat.logging, 1);
        pin_pulse(HOLD + 8);
        expect_trigs(1'b0, 1'b1);
        step(2 * TICK + 12);
        check("logging after post", stat.logging, 0);
        pulse(disarm);
        cfg.edge_sel = ETIO_EDGE_OFF;
        pulse(arm);
        pin_pulse(HOLD + 8);
        expect_trigs(1'b0, 1'b0);
        check("logging edge off", stat.logging, 0);
        pulse(disarm);
        cfg.edge_sel = ETIO_EDGE_BOTH;
        cfg.post_ms = 16'h0000;
        pulse(arm);
        pin_pulse(HOLD + 8);
        expect_trigs(1'b1, 1'b1);
        check("logging edge both", stat.logging, 1);
        // Each event select in turn; unselected bits toggle at random first
        for (int i = 0; i < 8; i++) begin
            cfg.out_event_mask = 8'h01 << i;
            rnd = 8'($random(seed));
            event_in = rnd & ~cfg.out_event_mask;
            step(4);
            check("trig_out unselected", n_out, 0);
            event_in[i] = 1'b1;
            step(PULSE + 6);
            check("trig_out length", n_out, PULSE);
            event_in = 8'h00;
            n_out = 0;
            step(2);
        end
        wrap_up;
    end
endmodule // tb_top
